// ===== hdl/fpma_regs.svh
// timing counts, map boundaries, command codes and security bit positions
`ifndef FPMA_REGS_SVH
`define FPMA_REGS_SVH
`define FPMA_ARRAY_KB          64
`define FPMA_USER_KB           62
`define FPMA_KERNEL_BASE       16'hF800
`define FPMA_BOOT62_BASE       16'hE000
`define FPMA_BOOT32_BASE       16'h6000
`define FPMA_SIZE32_TOP        16'h8000
`define FPMA_SIZE8_TOP         16'h2000
`define FPMA_DATA_BYTES        4096
`define FPMA_CMD_ERASE_ALL     4'h0
`define FPMA_CMD_PROG_CODE     4'hA
`define FPMA_CMD_PROG_DATA     4'h2
`define FPMA_CMD_READ_CODE     4'hB
`define FPMA_CMD_READ_DATA     4'h3
`define FPMA_CMD_PROG_SEC      4'hC
`define FPMA_CMD_READ_SEC      4'hD
`define FPMA_SEC_LOCK_BIT      0
`define FPMA_SEC_SECURE_BIT    1
`define FPMA_SEC_SAFE_BIT      2
`define FPMA_SEC_RESET         3'h0
`define FPMA_CAL_WORDS         8
`define FPMA_ERASED_BYTE       8'hFF
`endif

// ===== hdl/fpma_pkg.sv
// types shared by the program memory access logic
package fpma_pkg;
   typedef enum logic [2:0] {
      FPMA_CALIB    = 3'b000,
      FPMA_NORMAL   = 3'b001,
      FPMA_DOWNLOAD = 3'b010,
      FPMA_ERASE    = 3'b011,
      FPMA_USER_DOWNLOAD_MODE    = 3'b100
   } fpma_state_e;
   typedef enum logic [1:0] {
      FPMA_OPT_62K = 2'b00,
      FPMA_OPT_32K = 2'b01,
      FPMA_OPT_8K  = 2'b10
   } fpma_opt_e;
endpackage

// ===== hdl/fpma_mem.sv
// single-port byte memory with registered read data
`timescale 1ns/10ps
module fpma_mem #(
   parameter int AW = 16
) (
   input  wire logic          ref_clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [7:0]    wdata_i,
   output logic      [7:0]    rdata_o
);
   logic [7:0] mem_q [0:(1<<AW)-1];
   logic [7:0] rdata_q;
   always_ff @(posedge ref_clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_q <= mem_q[addr_i];
   end
   assign rdata_o = rdata_q;
endmodule

// ===== hdl/fpma_top.sv
// program and data nonvolatile memory access with strap and parallel programming
// Operation
// - 64 kbyte array, lower 62 kbyte user
// - user reads of top 2 kbyte return zero
// - calibration loaded at power-on before user code
// - normal mode: 62 kbyte contiguous block
// - normal mode: parallel programming allowed; serial download writes only in download mode
// - strobe pin low at reset enters download
// - download kernel writes whole user space
// - parallel: address ports 0/2, data port 3, strobe
// - command 0000 erases code, data, security
// - decode program/read code, data, security commands
// - data byte programmable only after page erase
// - boot area top 6k (62k) or 8k (32k)
// - 8 kbyte option has no user download
// - kernel stays protected at 62-64 kbyte
// - user download lets code rewrite program memory
// - normal mode program memory read-only to code
// - serial-safe bit is cleared by reset before the strap check, so a strap reset still enters download
`timescale 1ns/10ps
`include "fpma_regs.svh"
module fpma_top #(
   parameter fpma_pkg::fpma_opt_e OPTION = fpma_pkg::FPMA_OPT_62K
) (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        program_store_strobe_pin_n_i,
   input  wire logic        par_mode_i,
   input  wire logic [7:0]  port0_addr_i,
   input  wire logic [7:0]  port2_addr_i,
   input  wire logic [7:0]  port3_data_i,
   output logic      [7:0]  port3_data_o,
   output logic             port3_data_oe_o,
   input  wire logic        par_we_i,
   input  wire logic [3:0]  par_cmd_i,
   input  wire logic        user_download_mode_i,
   input  wire logic        dl_we_i,
   input  wire logic [15:0] dl_addr_i,
   input  wire logic [7:0]  dl_wdata_i,
   input  wire logic        code_re_i,
   input  wire logic        code_we_i,
   input  wire logic [15:0] code_addr_i,
   input  wire logic [7:0]  code_wdata_i,
   output logic      [7:0]  code_rdata_o,
   input  wire logic        data_we_i,
   input  wire logic        data_page_erase_i,
   input  wire logic [11:0] data_addr_i,
   input  wire logic [7:0]  data_wdata_i,
   output logic      [7:0]  data_rdata_o,
   output logic             cal_done_o,
   output logic [2:0]       mode_o,
   output logic [2:0]       security_o
);
   logic        rst_s1_q;
   logic        rst_n;
   fpma_pkg::fpma_state_e state_q, state_d;
   logic [2:0]  sec_q, sec_d;
   logic [3:0]  cal_q, cal_d;
   logic        strap_seen_q, strap_seen_d;
   logic [16:0] clr_q, clr_d;
   logic [1023:0] page_erased_q, page_erased_d;
   logic        last_we_q, last_we_d;
   logic [7:0]  p3_q, p3_d;
   logic        p3_oe_q, p3_oe_d;
   logic        zero_q, zero_d;
   logic        cmem_we, dmem_we;
   logic [15:0] cmem_addr;
   logic [7:0]  cmem_wdata, cmem_rd, dmem_rd;
   logic [11:0] dmem_addr;
   logic [7:0]  dmem_wdata;
   logic [15:0] par_addr;
   logic [15:0] user_top, boot_base;
   logic        par_ok, par_strobe;

   // reset release through two flops
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   assign par_addr   = {port2_addr_i, port0_addr_i};
   assign par_strobe = par_mode_i && par_we_i && !last_we_q;
   assign par_ok     = !sec_q[`FPMA_SEC_LOCK_BIT] && !sec_q[`FPMA_SEC_SECURE_BIT];

   // option dependent map
   always_comb begin
      unique case (OPTION)
         fpma_pkg::FPMA_OPT_62K: begin
            user_top  = `FPMA_KERNEL_BASE;
            boot_base = `FPMA_BOOT62_BASE;
         end
         fpma_pkg::FPMA_OPT_32K: begin
            user_top  = `FPMA_SIZE32_TOP;
            boot_base = `FPMA_BOOT32_BASE;
         end
         default: begin
            user_top  = `FPMA_SIZE8_TOP;
            boot_base = 16'h0000;
         end
      endcase
   end

   // mode, security, calibration and erase sequencing
   always_comb begin
      state_d       = state_q;
      sec_d         = sec_q;
      cal_d         = cal_q;
      clr_d         = clr_q;
      page_erased_d = page_erased_q;
      last_we_d     = par_we_i;
      p3_d          = p3_q;
      p3_oe_d       = 1'b0;
      zero_d        = 1'b0;
      cmem_we       = 1'b0;
      cmem_addr     = code_addr_i;
      cmem_wdata    = code_wdata_i;
      dmem_we       = 1'b0;
      dmem_addr     = data_addr_i;
      dmem_wdata    = data_wdata_i;
      unique case (state_q)
         fpma_pkg::FPMA_CALIB: begin
            if (cal_q == 4'(`FPMA_CAL_WORDS - 1)) begin
               if (!strap_seen_q && !sec_q[`FPMA_SEC_SAFE_BIT]) begin
                  state_d = fpma_pkg::FPMA_DOWNLOAD;
               end else begin
                  state_d = fpma_pkg::FPMA_NORMAL;
               end
            end else begin
               cal_d = cal_q + 4'h1;
            end
         end
         fpma_pkg::FPMA_DOWNLOAD: begin
            if (dl_we_i && dl_addr_i < user_top) begin
               cmem_we    = 1'b1;
               cmem_addr  = dl_addr_i;
               cmem_wdata = dl_wdata_i;
            end
         end
         fpma_pkg::FPMA_ERASE: begin
            cmem_we    = 1'b1;
            cmem_addr  = clr_q[15:0];
            cmem_wdata = `FPMA_ERASED_BYTE;
            dmem_we    = !clr_q[16] && clr_q[15:12] == 4'h0;
            dmem_addr  = clr_q[11:0];
            dmem_wdata = `FPMA_ERASED_BYTE;
            if (clr_q[15:0] >= user_top) begin
               cmem_we = 1'b0;
            end
            if (clr_q[15:0] == 16'hFFFF) begin
               page_erased_d = '1;
               sec_d         = `FPMA_SEC_RESET;
               state_d       = fpma_pkg::FPMA_NORMAL;
            end
            clr_d = clr_q + 17'h1;
         end
         default: begin
            if (state_q == fpma_pkg::FPMA_NORMAL && user_download_mode_i
                && OPTION != fpma_pkg::FPMA_OPT_8K) begin
               state_d = fpma_pkg::FPMA_USER_DOWNLOAD_MODE;
            end
            if (state_q == fpma_pkg::FPMA_USER_DOWNLOAD_MODE && !user_download_mode_i) begin
               state_d = fpma_pkg::FPMA_NORMAL;
            end
            // user code writes only in user download below boot area
            if (state_q == fpma_pkg::FPMA_USER_DOWNLOAD_MODE && code_we_i
                && code_addr_i < boot_base) begin
               cmem_we = 1'b1;
            end
            zero_d = code_re_i && code_addr_i >= user_top;
            if (data_page_erase_i) begin
               page_erased_d[data_addr_i[11:2]] = 1'b1;
               dmem_we    = 1'b1;
               dmem_wdata = `FPMA_ERASED_BYTE;
            end else if (data_we_i && page_erased_q[data_addr_i[11:2]]) begin
               dmem_we = 1'b1;
            end
            if (par_mode_i) begin
               // user port writes held off while the programmer owns the arrays
               cmem_we       = 1'b0;
               dmem_we       = 1'b0;
               page_erased_d = page_erased_q;
               cmem_addr = par_addr;
               dmem_addr = par_addr[11:0];
               p3_oe_d   = 1'b0;
               unique case (par_cmd_i)
                  `FPMA_CMD_READ_CODE: begin
                     p3_oe_d = !sec_q[`FPMA_SEC_SECURE_BIT];
                     p3_d    = cmem_rd;
                  end
                  `FPMA_CMD_READ_DATA: begin
                     p3_oe_d = 1'b1;
                     p3_d    = dmem_rd;
                  end
                  `FPMA_CMD_READ_SEC: begin
                     p3_oe_d = 1'b1;
                     p3_d    = {5'h00, sec_q};
                  end
                  default: begin
                     p3_d = p3_q;
                  end
               endcase
               if (par_strobe) begin
                  unique case (par_cmd_i)
                     `FPMA_CMD_ERASE_ALL: begin
                        clr_d   = 17'h0;
                        state_d = fpma_pkg::FPMA_ERASE;
                     end
                     `FPMA_CMD_PROG_CODE: begin
                        cmem_we    = par_ok && par_addr < user_top;
                        cmem_wdata = port3_data_i;
                     end
                     `FPMA_CMD_PROG_DATA: begin
                        dmem_we    = page_erased_q[par_addr[11:2]];
                        dmem_wdata = port3_data_i;
                     end
                     `FPMA_CMD_PROG_SEC: begin
                        sec_d = sec_q | port3_data_i[2:0];
                     end
                     default: begin
                        sec_d = sec_q;
                     end
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= fpma_pkg::FPMA_CALIB;
         sec_q         <= `FPMA_SEC_RESET;
         cal_q         <= 4'h0;
         strap_seen_q  <= 1'b1;
         clr_q         <= 17'h0;
         page_erased_q <= '0;
         last_we_q     <= 1'b0;
         p3_q          <= 8'h00;
         p3_oe_q       <= 1'b0;
         zero_q        <= 1'b0;
      end else begin
         state_q       <= state_d;
         sec_q         <= sec_d;
         cal_q         <= cal_d;
         strap_seen_q  <= strap_seen_d;
         clr_q         <= clr_d;
         page_erased_q <= page_erased_d;
         last_we_q     <= last_we_d;
         p3_q          <= p3_d;
         p3_oe_q       <= p3_oe_d;
         zero_q        <= zero_d;
      end
   end

   // strap caught on first clocked cycle after release
   always_comb begin
      strap_seen_d = strap_seen_q;
      if (state_q == fpma_pkg::FPMA_CALIB && cal_q == 4'h0) begin
         strap_seen_d = program_store_strobe_pin_n_i;
      end
   end

   fpma_mem #(.AW(16)) u_code (
      .ref_clk_i (ref_clk_i),
      .we_i      (cmem_we),
      .addr_i    (cmem_addr),
      .wdata_i   (cmem_wdata),
      .rdata_o   (cmem_rd)
   );

   fpma_mem #(.AW(12)) u_data (
      .ref_clk_i (ref_clk_i),
      .we_i      (dmem_we),
      .addr_i    (dmem_addr),
      .wdata_i   (dmem_wdata),
      .rdata_o   (dmem_rd)
   );

   assign code_rdata_o    = zero_q ? 8'h00 : cmem_rd;
   assign data_rdata_o    = dmem_rd;
   assign port3_data_o    = p3_q;
   assign port3_data_oe_o = p3_oe_q;
   assign cal_done_o      = state_q != fpma_pkg::FPMA_CALIB;
   assign mode_o          = state_q;
   assign security_o      = sec_q;

   a_kernel_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      code_re_i && !par_mode_i && state_q inside {fpma_pkg::FPMA_NORMAL,
      fpma_pkg::FPMA_USER_DOWNLOAD_MODE} && code_addr_i >= user_top |=> code_rdata_o == 8'h00)
      else $error("kernel area read not zero");
   a_normal_readonly: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == fpma_pkg::FPMA_NORMAL && !par_mode_i |-> !cmem_we)
      else $error("code written in normal mode");
   a_safe_strap: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == fpma_pkg::FPMA_CALIB && sec_q[`FPMA_SEC_SAFE_BIT] |=>
      state_q != fpma_pkg::FPMA_DOWNLOAD)
      else $error("serial safe ignored");
   a_kernel_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      cmem_we |-> cmem_addr < user_top)
      else $error("kernel area written");
   a_boot_protect: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == fpma_pkg::FPMA_USER_DOWNLOAD_MODE && !par_mode_i |-> !cmem_we || cmem_addr < boot_base)
      else $error("boot area written by user code");
   a_no_user_download_mode_8k: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      OPTION == fpma_pkg::FPMA_OPT_8K |-> state_q != fpma_pkg::FPMA_USER_DOWNLOAD_MODE)
      else $error("user download on 8k option");
   a_data_erased: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      dmem_we && state_q != fpma_pkg::FPMA_ERASE && !data_page_erase_i
      |-> page_erased_q[dmem_addr[11:2]])
      else $error("data byte written to unerased page");
   a_redundant_cmd: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      par_strobe && state_q == fpma_pkg::FPMA_NORMAL && !(par_cmd_i inside
      {4'h0, 4'hA, 4'h2, 4'hC}) |=> sec_q == $past(sec_q) && state_q == $past(state_q))
      else $error("redundant command had effect");
endmodule

// ===== dv/fpma_prog_model.sv
// external parallel programmer model driving the programming pins
`timescale 1ns/10ps
module fpma_prog_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] dut_p3_i,
   input  wire logic       dut_p3_oe_i,
   output logic            par_mode_o,
   output logic [7:0]      p0_o,
   output logic [7:0]      p2_o,
   output logic [7:0]      p3_o,
   output logic            we_o,
   output logic [3:0]      cmd_o
);
   logic [7:0] drv = 8'h00;
   logic       en  = 1'b0;
   // resolved port 3 wire; a released line shows the inverse of the last value
   assign p3_o = dut_p3_oe_i ? dut_p3_i : (en ? drv : ~drv);
   initial begin
      par_mode_o = 1'b0;
      {p2_o, p0_o} = 16'hFFFF;
      we_o = 1'b0;
      cmd_o = 4'hF;
   end
   // one command cycle: set up, strobe if writing, hold, sample the wire
   task automatic op(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d,
                     input logic wr, output logic [7:0] q, output logic oe);
      @(posedge clk_i);
      #1;
      par_mode_o = 1'b1;
      cmd_o = c;
      {p2_o, p0_o} = a;
      drv = d;
      en = wr;
      @(posedge clk_i);
      #1;
      we_o = wr;
      repeat (3) @(posedge clk_i);
      #1;
      q = p3_o;
      oe = dut_p3_oe_i;
      we_o = 1'b0;
      @(posedge clk_i);
      #1;
      par_mode_o = 1'b0;
      en = 1'b0;
   endtask
endmodule

// ===== dv/tb_top.sv
// self-checking testbench for the program memory access block
`timescale 1ns/10ps
module tb_top;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        strap_n = 1'b1;
   logic        par_mode, par_we, p3_oe, user_download_mode = 1'b0;
   logic [7:0]  p0, p2, p3_in, p3_out, q;
   logic [3:0]  cmd;
   logic        dl_we = 1'b0, code_re = 1'b0, code_we = 1'b0, data_we = 1'b0, pg_erase = 1'b0;
   logic [15:0] dl_addr = 16'h0000, code_addr = 16'h0000;
   logic [7:0]  dl_wdata = 8'h00, code_wdata = 8'h00, code_rdata, data_wdata = 8'h00;
   logic [7:0]  data_rdata;
   logic [11:0] data_addr = 12'h000;
   logic        cal_done, oe;
   logic [2:0]  mode, sec, mode8;
   int          miscompares = 0;
   int          cmp_count = 0;
   always #2.5 clk = ~clk;
   fpma_prog_model prog (.clk_i(clk), .dut_p3_i(p3_out), .dut_p3_oe_i(p3_oe),
      .par_mode_o(par_mode), .p0_o(p0), .p2_o(p2), .p3_o(p3_in), .we_o(par_we), .cmd_o(cmd));
   fpma_top dut (.ref_clk_i(clk), .resetn_i(resetn), .program_store_strobe_pin_n_i(strap_n),
      .par_mode_i(par_mode), .port0_addr_i(p0), .port2_addr_i(p2), .port3_data_i(p3_in),
      .port3_data_o(p3_out), .port3_data_oe_o(p3_oe), .par_we_i(par_we), .par_cmd_i(cmd),
      .user_download_mode_i(user_download_mode), .dl_we_i(dl_we), .dl_addr_i(dl_addr),
      .dl_wdata_i(dl_wdata), .code_re_i(code_re), .code_we_i(code_we),
      .code_addr_i(code_addr), .code_wdata_i(code_wdata), .code_rdata_o(code_rdata),
      .data_we_i(data_we), .data_page_erase_i(pg_erase), .data_addr_i(data_addr),
      .data_wdata_i(data_wdata), .data_rdata_o(data_rdata), .cal_done_o(cal_done),
      .mode_o(mode), .security_o(sec));
   fpma_top #(.OPTION(fpma_pkg::FPMA_OPT_8K)) dut_8k (.ref_clk_i(clk), .resetn_i(resetn),
      .program_store_strobe_pin_n_i(strap_n), .par_mode_i(par_mode), .port0_addr_i(p0),
      .port2_addr_i(p2), .port3_data_i(p3_in), .port3_data_o(), .port3_data_oe_o(),
      .par_we_i(par_we), .par_cmd_i(cmd), .user_download_mode_i(user_download_mode), .dl_we_i(dl_we),
      .dl_addr_i(dl_addr), .dl_wdata_i(dl_wdata), .code_re_i(code_re),
      .code_we_i(code_we), .code_addr_i(code_addr), .code_wdata_i(code_wdata),
      .code_rdata_o(), .data_we_i(data_we), .data_page_erase_i(pg_erase),
      .data_addr_i(data_addr), .data_wdata_i(data_wdata), .data_rdata_o(),
      .cal_done_o(), .mode_o(mode8), .security_o());
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset(input logic s);
      strap_n = s;
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("mode in reset", 8'h00, {5'h00, mode});
      chk("oe in reset", 8'h00, {7'h00, p3_oe});
      resetn = 1'b1;
      for (int i = 0; i < 40 && cal_done !== 1'b1; i++) @(posedge clk);
      #1;
      chk("cal done", 8'h01, {7'h00, cal_done});
   endtask
   task automatic cread(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      code_addr = a;
      code_re = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      d = code_rdata;
      code_re = 1'b0;
   endtask
   task automatic cwrite(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      code_addr = a;
      code_wdata = d;
      code_we = 1'b1;
      @(posedge clk);
      #1;
      code_we = 1'b0;
   endtask
   task automatic t_download;
      do_reset(1'b0);
      chk("download mode", 8'h02, {5'h00, mode});
      dl_addr = 16'h1234;
      dl_wdata = 8'h5A;
      dl_we = 1'b1;
      @(posedge clk);
      #1;
      dl_we = 1'b0;
      do_reset(1'b1);
      chk("normal mode", 8'h01, {5'h00, mode});
      cread(16'h1234, q);
      chk("kernel byte", 8'h5A, q);
   endtask
   task automatic t_par_code;
      prog.op(4'hA, 16'h0100, 8'h3C, 1'b1, q, oe);
      prog.op(4'hB, 16'h0100, 8'h00, 1'b0, q, oe);
      chk("par code read", 8'h3C, q);
      chk("par read oe", 8'h01, {7'h00, oe});
      prog.op(4'hA, 16'hF7FF, 8'h81, 1'b1, q, oe);
      cread(16'hF7FF, q);
      chk("top user byte", 8'h81, q);
      cread(16'hF800, q);
      chk("kernel hidden", 8'h00, q);
      cwrite(16'h0100, 8'hEE);
      cread(16'h0100, q);
      chk("normal write ignored", 8'h3C, q);
   endtask
   task automatic t_redundant;
      logic [3:0] codes [9] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE, 4'hF};
      foreach (codes[i]) prog.op(codes[i], 16'h0100, 8'h00, 1'b1, q, oe);
      prog.op(4'hB, 16'h0100, 8'h00, 1'b0, q, oe);
      chk("redundant code", 8'h3C, q);
      chk("redundant sec", 8'h00, {5'h00, sec});
   endtask
   task automatic t_data;
      data_addr = 12'h010;
      pg_erase = 1'b1;
      @(posedge clk);
      #1;
      pg_erase = 1'b0;
      data_addr = 12'h011;
      data_wdata = 8'h66;
      data_we = 1'b1;
      @(posedge clk);
      #1;
      data_we = 1'b0;
      prog.op(4'h2, 16'h0010, 8'h77, 1'b1, q, oe);
      prog.op(4'h3, 16'h0010, 8'h00, 1'b0, q, oe);
      chk("par data read", 8'h77, q);
      @(posedge clk);
      #1;
      chk("data byte", 8'h66, data_rdata);
   endtask
   task automatic t_security;
      prog.op(4'hC, 16'h0000, 8'h01, 1'b1, q, oe);
      chk("lock set", 8'h01, {5'h00, sec});
      prog.op(4'hA, 16'h0100, 8'h99, 1'b1, q, oe);
      prog.op(4'hB, 16'h0100, 8'h00, 1'b0, q, oe);
      chk("locked program", 8'h3C, q);
      prog.op(4'hC, 16'h0000, 8'h06, 1'b1, q, oe);
      prog.op(4'hD, 16'h0000, 8'h00, 1'b0, q, oe);
      chk("all sec bits", 8'h07, {5'h00, sec});
      chk("sec readback", 8'h07, q);
      prog.op(4'hB, 16'h0100, 8'h00, 1'b0, q, oe);
      chk("secure hides", 8'h00, {7'h00, oe});
      prog.op(4'h0, 16'h0000, 8'h00, 1'b1, q, oe);
      chk("erase mode", 8'h03, {5'h00, mode});
      for (int i = 0; i < 70000 && mode !== 3'h1; i++) @(posedge clk);
      #1;
      chk("after erase", 8'h01, {5'h00, mode});
      chk("sec cleared", 8'h00, {5'h00, sec});
      cread(16'h0100, q);
      chk("code erased", 8'hFF, q);
      data_addr = 12'h010;
      @(posedge clk);
      #1;
      chk("data erased", 8'hFF, data_rdata);
   endtask
   task automatic t_user_download_mode;
      user_download_mode = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("user_download_mode mode", 8'h04, {5'h00, mode});
      chk("8k no user_download_mode", 8'h01, {5'h00, mode8});
      cwrite(16'h0200, 8'h42);
      cwrite(16'hE000, 8'h24);
      cread(16'h0200, q);
      chk("user_download_mode write", 8'h42, q);
      cread(16'hE000, q);
      chk("boot protected", 8'hFF, q);
      user_download_mode = 1'b0;
   endtask
   task automatic conclude;
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   initial begin
      t_download();
      t_par_code();
      t_redundant();
      t_data();
      t_security();
      t_user_download_mode();
      conclude();
   end
endmodule
